// File: common/sbpcr_pkg.sv
package sbpcr_pkg;

  // Register indices; the byte address is four times the index
  localparam logic [7:0] IDX_SERIAL_ROLE = 8'h5b;
  localparam logic [7:0] IDX_BURST_LOW = 8'h5c;
  localparam logic [7:0] IDX_STARTUP_SRC = 8'h5e;
  localparam logic [7:0] IDX_RX_DIV_CFG = 8'h5f;
  localparam logic [7:0] IDX_RX_PWR_CFG = 8'h61;
  localparam logic [7:0] IDX_RX_LOCK = 8'h64;
  localparam logic [7:0] IDX_TX_DIV_CFG = 8'h65;
  localparam logic [7:0] IDX_TX_PWR_CFG = 8'h66;
  localparam logic [7:0] IDX_TX_LOCK = 8'h69;
  localparam logic [7:0] IDX_SH_PWR_CFG = 8'h6a;
  localparam logic [7:0] IDX_SH_FB_LOW = 8'h6b;
  localparam logic [7:0] IDX_IRQ_STATUS = 8'h80;
  localparam logic [7:0] IDX_IRQ_MASK = 8'h81;
  localparam logic [7:0] IDX_BURST_KICK = 8'h82;

  // Reset values
  localparam logic [7:0] RST_SERIAL_ROLE = 8'h90;
  localparam logic [7:0] RST_BURST_LOW = 8'h00;
  localparam logic [7:0] RST_STARTUP_SRC = 8'h01;
  localparam logic [7:0] RST_RX_DIV_CFG = 8'h60;
  localparam logic [7:0] RST_TX_DIV_CFG = 8'h30;
  localparam logic [7:0] RST_PWR_CFG = 8'h07;
  localparam logic [7:0] RST_SH_PWR_CFG = 8'he0;
  localparam logic [7:0] RST_SH_FB_LOW = 8'h12;

  // Writable bit masks
  localparam logic [7:0] WM_SERIAL_ROLE = 8'hff;
  localparam logic [7:0] WM_STARTUP_SRC = 8'h01;
  localparam logic [7:0] WM_DIV_CFG = 8'h7f;
  localparam logic [7:0] WM_PWR_CFG = 8'h3f;
  localparam logic [7:0] WM_IRQ = 8'h03;

  // Field positions
  localparam int MODE_BIT = 0;
  localparam int SEL_LSB = 1;
  localparam int BMSB_LSB = 3;
  localparam int FB_LSB = 4;
  localparam int PD_LSB = 3;
  localparam int LOCK_BIT = 7;
  localparam int SH_PD_BIT = 7;
  localparam int SH_DSM_BIT = 6;
  localparam int SH_DAC_BIT = 5;
  localparam int SH_BYP_BIT = 4;
  localparam int IRQ_DONE_BIT = 0;
  localparam int IRQ_LOCK_BIT = 1;

  localparam logic [3:0] FB_OFFSET = 4'h2;

  typedef struct packed {
    logic pll_off;
    logic div_off;
    logic drv_off;
    logic [3:0] post_ratio;
    logic [3:0] fb_ratio;
    logic [3:0] phase_sel;
  } sbpcr_synth_type;

endpackage

// File: dv/tb_serial_boot_pll_config_regs.sv
`timescale 1ns/100ps
module tb_serial_boot_pll_config_regs;
  import sbpcr_pkg::*;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic psel_i = 1'b0;
  logic penable_i = 1'b0;
  logic pwrite_i = 1'b0;
  logic [31:0] paddr_i = 32'h0000_0000;
  logic [31:0] pwdata_i = 32'h0000_0000;
  logic [3:0] pstrb_i = 4'h0;
  logic rx_lock_i = 1'b0;
  logic tx_lock_i = 1'b0;
  logic q_valid_i = 1'b0;
  logic [7:0] q_data_i = 8'h00;
  logic [31:0] prdata_o;
  logic pready_o, pslverr_o, q_ready_o, tx_byte_valid_o;
  logic [7:0] tx_byte_o;
  logic master_mode_o, boot_from_rom_o, burst_busy_o, irq_o;
  logic chip_select_out_zero_o, chip_select_out_one_o, chip_select_out_two_o;
  sbpcr_synth_type rx_synth_o, tx_synth_o;
  logic sh_pd_o, sh_dsm_pd_o, sh_dac_pd_o, sh_bypass_o;
  logic [11:0] sh_fbdiv_o;
  int fail_count = 0;
  int comparisons = 0;
  int cycles = 0;
  int seed = 45;
  logic [31:0] rdat;
  logic rerr;
  logic [7:0] m [0:255];
  logic [7:0] off_q [$];
  logic [7:0] got_q [$];
  logic [7:0] rw_idx [9] = '{IDX_SERIAL_ROLE, IDX_BURST_LOW, IDX_STARTUP_SRC,
    IDX_RX_DIV_CFG, IDX_RX_PWR_CFG, IDX_TX_DIV_CFG, IDX_TX_PWR_CFG,
    IDX_SH_PWR_CFG, IDX_SH_FB_LOW};

  sbpcr_regs sbpcr_regs_i (
    .clk_i(clk_i), .rst_i(rst_i), .psel_i(psel_i), .penable_i(penable_i),
    .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
    .pstrb_i(pstrb_i), .prdata_o(prdata_o), .pready_o(pready_o),
    .pslverr_o(pslverr_o), .rx_lock_i(rx_lock_i), .tx_lock_i(tx_lock_i),
    .q_valid_i(q_valid_i), .q_data_i(q_data_i), .q_ready_o(q_ready_o),
    .tx_byte_valid_o(tx_byte_valid_o), .tx_byte_o(tx_byte_o),
    .master_mode_o(master_mode_o),
    .chip_select_out_zero_o(chip_select_out_zero_o),
    .chip_select_out_one_o(chip_select_out_one_o),
    .chip_select_out_two_o(chip_select_out_two_o),
    .boot_from_rom_o(boot_from_rom_o), .rx_synth_o(rx_synth_o),
    .tx_synth_o(tx_synth_o), .sh_pd_o(sh_pd_o), .sh_dsm_pd_o(sh_dsm_pd_o),
    .sh_dac_pd_o(sh_dac_pd_o), .sh_bypass_o(sh_bypass_o),
    .sh_fbdiv_o(sh_fbdiv_o), .burst_busy_o(burst_busy_o), .irq_o(irq_o)
  );

  // ----------------------------------------
  // Clock, timeout and byte monitor
  // ----------------------------------------
  always #10 clk_i = ~clk_i;

  always @(posedge clk_i) begin
    cycles++;
    if (tx_byte_valid_o === 1'b1) got_q.push_back(tx_byte_o);
    if (cycles == 20000) begin
      fail_count++;
      test_done();
    end
  end

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  task automatic test_done();
    $display("comparisons %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Request held until pready is sampled high; answer taken at that edge
  task automatic apb(input logic w, input logic [7:0] idx,
                     input logic [7:0] d, input logic [3:0] strb);
    int n;
    @(posedge clk_i);
    psel_i <= 1'b1;
    penable_i <= 1'b0;
    pwrite_i <= w;
    paddr_i <= {22'h0, idx, 2'b00};
    pwdata_i <= {24'h0, d};
    pstrb_i <= strb;
    @(posedge clk_i);
    penable_i <= 1'b1;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (pready_o !== 1'b1 && n < 16);
    if (n >= 16) chk(pready_o, 1'b1);
    rdat = prdata_o;
    rerr = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    apb(1'b1, idx, d, 4'hf);
  endtask

  task automatic rdchk(input logic [7:0] idx, input logic [7:0] exp,
                       input logic err);
    apb(1'b0, idx, 8'h00, 4'hf);
    chk(rdat, {24'h0, exp});
    chk(rerr, err);
  endtask

  function automatic logic [7:0] wmask(input logic [7:0] idx);
    if (idx == IDX_STARTUP_SRC) return 8'h01;
    if (idx == IDX_RX_DIV_CFG || idx == IDX_TX_DIV_CFG) return 8'h7f;
    if (idx == IDX_RX_PWR_CFG || idx == IDX_TX_PWR_CFG) return 8'h3f;
    return 8'hff;
  endfunction

  function automatic sbpcr_synth_type synth(input logic [7:0] dv,
                                            input logic [7:0] pw);
    sbpcr_synth_type s;
    s.pll_off = pw[2];
    s.div_off = pw[1];
    s.drv_off = pw[0];
    s.post_ratio = (pw[5:3] == 3'h0) ? 4'h5 : {1'b0, pw[5:3]} + 4'h1;
    s.fb_ratio = {1'b0, dv[6:4]} + 4'h2;
    s.phase_sel = dv[3:0];
    return s;
  endfunction

  task automatic check_outs();
    logic mm;
    logic [1:0] sel;
    logic [7:0] sh;
    mm = m[IDX_SERIAL_ROLE][0];
    sel = m[IDX_SERIAL_ROLE][2:1];
    sh = m[IDX_SH_PWR_CFG];
    chk(master_mode_o, mm);
    chk({chip_select_out_zero_o, chip_select_out_one_o,
         chip_select_out_two_o},
        {mm && sel == 2'h0, mm && sel == 2'h1, mm && sel == 2'h2});
    chk(boot_from_rom_o, m[IDX_STARTUP_SRC][0]);
    chk(rx_synth_o, synth(m[IDX_RX_DIV_CFG], m[IDX_RX_PWR_CFG]));
    chk(tx_synth_o, synth(m[IDX_TX_DIV_CFG], m[IDX_TX_PWR_CFG]));
    chk({sh_pd_o, sh_dsm_pd_o, sh_dac_pd_o, sh_bypass_o},
        {sh[7:5], sh[4] & ~sh[7]});
    chk(sh_fbdiv_o, {sh[3:0], m[IDX_SH_FB_LOW]});
  endtask

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    int k;
    logic [7:0] idx, d;
    logic [3:0] strb;
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    m[IDX_SERIAL_ROLE] = 8'h90;
    m[IDX_BURST_LOW] = 8'h00;
    m[IDX_STARTUP_SRC] = 8'h01;
    m[IDX_RX_DIV_CFG] = 8'h60;
    m[IDX_TX_DIV_CFG] = 8'h30;
    m[IDX_RX_PWR_CFG] = 8'h07;
    m[IDX_TX_PWR_CFG] = 8'h07;
    m[IDX_SH_PWR_CFG] = 8'he0;
    m[IDX_SH_FB_LOW] = 8'h12;
    for (k = 0; k < 9; k++) rdchk(rw_idx[k], m[rw_idx[k]], 1'b0);
    rdchk(IDX_RX_LOCK, 8'h00, 1'b0);
    rdchk(IDX_TX_LOCK, 8'h00, 1'b0);
    check_outs();
    $display("test reset values done");
    // Random traffic keeps select code and shared divider legal
    for (k = 0; k < 60; k++) begin
      idx = rw_idx[$unsigned($random(seed)) % 9];
      d = 8'($random(seed));
      strb = ($random(seed) & 3) == 0 ? 4'he : 4'hf;
      if (idx == IDX_SERIAL_ROLE && d[2:1] == 2'h3) d[2] = 1'b0;
      if (idx == IDX_SH_PWR_CFG && d[3:0] > 4'h5) d[3:0] = 4'h5;
      if (idx == IDX_SH_PWR_CFG && d[3:0] == 4'h0) d[4] = 1'b1;
      if (idx == IDX_SH_PWR_CFG && d[3:0] == 4'h0) d[3:0] = 4'h1;
      if (idx == IDX_SH_FB_LOW && m[IDX_SH_PWR_CFG][3:0] == 4'h0)
        d[4] = 1'b1;
      apb(1'b1, idx, d, strb);
      if (strb[0]) m[idx] = d & wmask(idx);
      rdchk(idx, m[idx], 1'b0);
      check_outs();
    end
    $display("test random writes done");
    wr(IDX_IRQ_MASK, 8'h00);
    wr(IDX_IRQ_STATUS, 8'h03);
    @(posedge clk_i);
    rx_lock_i <= 1'b1;
    tx_lock_i <= 1'b1;
    repeat (4) @(posedge clk_i);
    rdchk(IDX_RX_LOCK, 8'h80, 1'b0);
    wr(IDX_TX_LOCK, 8'hff);
    rdchk(IDX_TX_LOCK, 8'h80, 1'b0);
    rx_lock_i <= 1'b0;
    repeat (4) @(posedge clk_i);
    rdchk(IDX_RX_LOCK, 8'h00, 1'b0);
    rdchk(IDX_IRQ_STATUS, 8'h02, 1'b0);
    chk(irq_o, 1'b0);
    wr(IDX_IRQ_MASK, 8'h02);
    @(posedge clk_i);
    chk(irq_o, 1'b1);
    wr(IDX_IRQ_STATUS, 8'h02);
    @(posedge clk_i);
    chk(irq_o, 1'b0);
    $display("test lock and interrupt done");
    rdchk(8'h70, 8'h00, 1'b1);
    wr(8'h5d, 8'h55);
    rdchk(8'h5d, 8'h00, 1'b1);
    $display("test unmapped done");
    wr(IDX_SERIAL_ROLE, 8'h00);
    wr(IDX_BURST_KICK, 8'h01);
    @(posedge clk_i);
    chk(burst_busy_o, 1'b0);
    wr(IDX_SERIAL_ROLE, 8'h01);
    wr(IDX_BURST_LOW, 8'h03);
    wr(IDX_IRQ_MASK, 8'h01);
    wr(IDX_BURST_KICK, 8'h01);
    got_q.delete();
    for (k = 0; k < 12; k++) begin
      @(posedge clk_i);
      d = 8'($random(seed));
      q_valid_i <= d[0] | (k > 7);
      q_data_i <= 8'ha0 + k[7:0];
      if (d[0] | (k > 7)) off_q.push_back(8'ha0 + k[7:0]);
    end
    @(posedge clk_i);
    q_valid_i <= 1'b0;
    repeat (3) @(posedge clk_i);
    chk(got_q.size(), 3);
    for (k = 0; k < 3; k++) chk(got_q[k], off_q[k]);
    chk(burst_busy_o, 1'b0);
    chk(irq_o, 1'b1);
    rdchk(IDX_IRQ_STATUS, 8'h01, 1'b0);
    chk(q_ready_o, 1'b0);
    $display("test burst done");
    test_done();
  end
endmodule

// File: hdl/sbpcr_regs.sv
// Our own choice: the APB slave port.
`timescale 1ns/100ps
// Notes on behaviour
// - Role bit 0: zero selects slave operation, one selects master.
// - Select field routes chip select to output 0..2; code 3 unused.
// - Burst length is 13 bits: five high bits plus low register.
// - Master burst sends exactly burst length bytes as queue data arrives.
// - Boot bit resets high for boot ROM; zero starts from SRAM.
// - Receive feedback ratio is code plus two, reset code six.
// - Transmit feedback ratio is code plus two, reset code three.
// - Post divider code zero means five, others mean code plus one.
// - Receive synth has three power-down bits, all reset high.
// - Transmit synth has three power-down bits, all reset high.
// - Bits 3:0 select test output phase, reset zero.
// - Receive lock register read-only, bit 7 lock, rest zero.
// - Transmit lock register read-only, bit 7 lock, rest zero.
// - Shared synth resets with power, modulator and DAC powered down.
// - Bypass bit drives bypass pin; output off while powered down.
// - Shared feedback divider is 12 bits, low byte resets 0x12.
module sbpcr_regs
  import sbpcr_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [31:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic [3:0] pstrb_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  input wire logic rx_lock_i,
  input wire logic tx_lock_i,
  input wire logic q_valid_i,
  input wire logic [7:0] q_data_i,
  output logic q_ready_o,
  output logic tx_byte_valid_o,
  output logic [7:0] tx_byte_o,
  output logic master_mode_o,
  output logic chip_select_out_zero_o,
  output logic chip_select_out_one_o,
  output logic chip_select_out_two_o,
  output logic boot_from_rom_o,
  output sbpcr_synth_type rx_synth_o,
  output sbpcr_synth_type tx_synth_o,
  output logic sh_pd_o,
  output logic sh_dsm_pd_o,
  output logic sh_dac_pd_o,
  output logic sh_bypass_o,
  output logic [11:0] sh_fbdiv_o,
  output logic burst_busy_o,
  output logic irq_o
);

  // ----------------------------------------------------------------
  // Register storage
  // ----------------------------------------------------------------
  logic [7:0] serial_role_and_select;
  logic [7:0] burst_length_low;
  logic [7:0] startup_source_select;
  logic [7:0] receive_synth_divider_cfg;
  logic [7:0] receive_synth_output_power_cfg;
  logic [7:0] transmit_synth_divider_cfg;
  logic [7:0] transmit_synth_output_power_cfg;
  logic [7:0] shared_synth_power_bypass_cfg;
  logic [7:0] shared_synth_feedback_low;
  logic [7:0] irq_status;
  logic [7:0] irq_mask;
  logic [12:0] burst_left;
  logic [1:0] rx_lock_sync;
  logic [1:0] tx_lock_sync;
  logic lock_prev;

  // ----------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------
  wire logic [7:0] idx = paddr_i[9:2];
  wire logic addr_ok = (paddr_i[31:10] == 22'h00_0000) &&
                       (paddr_i[1:0] == 2'b00);
  wire logic acc = psel_i && penable_i;
  wire logic wr = acc && pwrite_i && pstrb_i[0] && addr_ok;
  wire logic wr_role = wr && (idx == IDX_SERIAL_ROLE);
  wire logic wr_blow = wr && (idx == IDX_BURST_LOW);
  wire logic wr_boot = wr && (idx == IDX_STARTUP_SRC);
  wire logic wr_rxd = wr && (idx == IDX_RX_DIV_CFG);
  wire logic wr_rxp = wr && (idx == IDX_RX_PWR_CFG);
  wire logic wr_txd = wr && (idx == IDX_TX_DIV_CFG);
  wire logic wr_txp = wr && (idx == IDX_TX_PWR_CFG);
  wire logic wr_shp = wr && (idx == IDX_SH_PWR_CFG);
  wire logic wr_shf = wr && (idx == IDX_SH_FB_LOW);
  wire logic wr_ist = wr && (idx == IDX_IRQ_STATUS);
  wire logic wr_imk = wr && (idx == IDX_IRQ_MASK);
  wire logic wr_kick = wr && (idx == IDX_BURST_KICK) && pwdata_i[0];
  wire logic [7:0] wd = pwdata_i[7:0];

  function automatic logic [7:0] masked(input logic [7:0] v,
                                        input logic [7:0] m);
    masked = v & m;
  endfunction

  function automatic logic [3:0] fb_ratio(input logic [2:0] c);
    fb_ratio = {1'b0, c} + FB_OFFSET;
  endfunction

  function automatic logic [3:0] post_ratio(input logic [2:0] c);
    post_ratio = (c == 3'h0) ? 4'h5 : ({1'b0, c} + 4'h1);
  endfunction

  logic known;
  logic [7:0] rd_byte;
  always_comb begin
    known = 1'b1;
    unique case (idx)
      IDX_SERIAL_ROLE: rd_byte = serial_role_and_select;
      IDX_BURST_LOW: rd_byte = burst_length_low;
      IDX_STARTUP_SRC: rd_byte = startup_source_select;
      IDX_RX_DIV_CFG: rd_byte = receive_synth_divider_cfg;
      IDX_RX_PWR_CFG: rd_byte = receive_synth_output_power_cfg;
      IDX_RX_LOCK: rd_byte = {rx_lock_sync[1], 7'h00};
      IDX_TX_DIV_CFG: rd_byte = transmit_synth_divider_cfg;
      IDX_TX_PWR_CFG: rd_byte = transmit_synth_output_power_cfg;
      IDX_TX_LOCK: rd_byte = {tx_lock_sync[1], 7'h00};
      IDX_SH_PWR_CFG: rd_byte = shared_synth_power_bypass_cfg;
      IDX_SH_FB_LOW: rd_byte = shared_synth_feedback_low;
      IDX_IRQ_STATUS: rd_byte = irq_status;
      IDX_IRQ_MASK: rd_byte = irq_mask;
      IDX_BURST_KICK: rd_byte = 8'h00;
      default: begin
        rd_byte = 8'h00;
        known = 1'b0;
      end
    endcase
  end

  wire logic hit = known && addr_ok;
  assign pready_o = 1'b1;
  // Unmapped or misaligned accesses error; zero-wait slave
  assign pslverr_o = acc && !hit;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      prdata_o <= 32'h0000_0000;
    end else if (psel_i && !penable_i && !pwrite_i) begin
      prdata_o <= {24'h00_0000, hit ? rd_byte : 8'h00};
    end
  end

  // ----------------------------------------------------------------
  // Configuration registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      serial_role_and_select <= RST_SERIAL_ROLE;
      burst_length_low <= RST_BURST_LOW;
      startup_source_select <= RST_STARTUP_SRC;
      receive_synth_divider_cfg <= RST_RX_DIV_CFG;
      receive_synth_output_power_cfg <= RST_PWR_CFG;
      transmit_synth_divider_cfg <= RST_TX_DIV_CFG;
      transmit_synth_output_power_cfg <= RST_PWR_CFG;
      shared_synth_power_bypass_cfg <= RST_SH_PWR_CFG;
      shared_synth_feedback_low <= RST_SH_FB_LOW;
      irq_mask <= 8'h00;
    end else begin
      if (wr_role) serial_role_and_select <= masked(wd, WM_SERIAL_ROLE);
      if (wr_blow) burst_length_low <= wd;
      if (wr_boot) startup_source_select <= masked(wd, WM_STARTUP_SRC);
      if (wr_rxd) receive_synth_divider_cfg <= masked(wd, WM_DIV_CFG);
      if (wr_rxp) receive_synth_output_power_cfg <= masked(wd, WM_PWR_CFG);
      if (wr_txd) transmit_synth_divider_cfg <= masked(wd, WM_DIV_CFG);
      if (wr_txp) transmit_synth_output_power_cfg <= masked(wd, WM_PWR_CFG);
      if (wr_shp) shared_synth_power_bypass_cfg <= wd;
      if (wr_shf) shared_synth_feedback_low <= wd;
      if (wr_imk) irq_mask <= masked(wd, WM_IRQ);
    end
  end

  // ----------------------------------------------------------------
  // Control outputs
  // ----------------------------------------------------------------
  wire logic [1:0] cs_code = serial_role_and_select[SEL_LSB +: 2];
  assign master_mode_o = serial_role_and_select[MODE_BIT];
  assign chip_select_out_zero_o = master_mode_o && (cs_code == 2'd0);
  assign chip_select_out_one_o = master_mode_o && (cs_code == 2'd1);
  assign chip_select_out_two_o = master_mode_o && (cs_code == 2'd2);
  assign boot_from_rom_o = startup_source_select[0];

  function automatic sbpcr_synth_type synth(input logic [7:0] dv,
                                            input logic [7:0] pw);
    synth.pll_off = pw[2];
    synth.div_off = pw[1];
    synth.drv_off = pw[0];
    synth.post_ratio = post_ratio(pw[PD_LSB +: 3]);
    synth.fb_ratio = fb_ratio(dv[FB_LSB +: 3]);
    synth.phase_sel = dv[3:0];
  endfunction

  assign rx_synth_o = synth(receive_synth_divider_cfg,
                            receive_synth_output_power_cfg);
  assign tx_synth_o = synth(transmit_synth_divider_cfg,
                            transmit_synth_output_power_cfg);

  assign sh_pd_o = shared_synth_power_bypass_cfg[SH_PD_BIT];
  assign sh_dsm_pd_o = shared_synth_power_bypass_cfg[SH_DSM_BIT];
  assign sh_dac_pd_o = shared_synth_power_bypass_cfg[SH_DAC_BIT];
  assign sh_bypass_o = shared_synth_power_bypass_cfg[SH_BYP_BIT] && !sh_pd_o;
  assign sh_fbdiv_o = {shared_synth_power_bypass_cfg[3:0],
                       shared_synth_feedback_low};

  // ----------------------------------------------------------------
  // Radar burst pump
  // ----------------------------------------------------------------
  wire logic [12:0] burst_len = {serial_role_and_select[BMSB_LSB +: 5],
                                 burst_length_low};
  assign burst_busy_o = (burst_left != 13'h0000);
  // Stall the queue only when idle; ready for every byte, the last included, while a burst is active
  assign q_ready_o = burst_busy_o;
  wire logic take = q_valid_i && q_ready_o;
  wire logic burst_done = take && (burst_left == 13'h0001);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      burst_left <= 13'h0000;
      tx_byte_valid_o <= 1'b0;
      tx_byte_o <= 8'h00;
    end else begin
      tx_byte_valid_o <= take;
      if (take) tx_byte_o <= q_data_i;
      if (take) begin
        burst_left <= burst_left - 13'h0001;
      end else if (wr_kick && master_mode_o && !burst_busy_o) begin
        burst_left <= burst_len;
      end
    end
  end

  // ----------------------------------------------------------------
  // Lock sync and interrupts
  // ----------------------------------------------------------------
  wire logic lock_lost = lock_prev && !rx_lock_sync[1];
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rx_lock_sync <= 2'b00;
      tx_lock_sync <= 2'b00;
      lock_prev <= 1'b0;
      irq_status <= 8'h00;
    end else begin
      rx_lock_sync <= {rx_lock_sync[0], rx_lock_i};
      tx_lock_sync <= {tx_lock_sync[0], tx_lock_i};
      lock_prev <= rx_lock_sync[1];
      // Set wins over write-one-to-clear
      irq_status <= (irq_status & ~(wr_ist ? masked(wd, WM_IRQ) : 8'h00))
                    | {6'h00, lock_lost, burst_done};
    end
  end
  assign irq_o = |(irq_status & irq_mask);

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  property p_role;
    @(posedge clk_i) disable iff (rst_i)
    wr_role |=> master_mode_o == $past(wd[0]);
  endproperty
  a_role: assert property (p_role) else $error("role bit wrong");

  property p_cs;
    @(posedge clk_i) disable iff (rst_i)
    (master_mode_o && cs_code == 2'd1) |-> chip_select_out_one_o &&
      !chip_select_out_zero_o && !chip_select_out_two_o;
  endproperty
  a_cs: assert property (p_cs) else $error("chip select route");

  property p_burst_load;
    @(posedge clk_i) disable iff (rst_i)
    (wr_kick && master_mode_o && !burst_busy_o) |=>
      burst_left == $past(burst_len);
  endproperty
  a_burst_load: assert property (p_burst_load) else $error("burst len");

  sequence s_last_take;
    take && burst_left == 13'h0001;
  endsequence
  property p_burst_end;
    @(posedge clk_i) disable iff (rst_i)
    s_last_take |=> !burst_busy_o && !q_ready_o && irq_status[IRQ_DONE_BIT];
  endproperty
  a_burst_end: assert property (p_burst_end) else $error("burst end");

  property p_boot;
    @(posedge clk_i) disable iff (rst_i)
    wr_boot && !wd[0] |=> !boot_from_rom_o;
  endproperty
  a_boot: assert property (p_boot) else $error("boot source");

  property p_fb;
    @(posedge clk_i) disable iff (rst_i)
    rx_synth_o.fb_ratio == {1'b0, receive_synth_divider_cfg[6:4]} + 4'h2;
  endproperty
  a_fb: assert property (p_fb) else $error("rx fb ratio");

  property p_post;
    @(posedge clk_i) disable iff (rst_i)
    transmit_synth_output_power_cfg[5:3] == 3'h0 |->
      tx_synth_o.post_ratio == 4'h5;
  endproperty
  a_post: assert property (p_post) else $error("post ratio");

  property p_lock;
    @(posedge clk_i) disable iff (rst_i)
    $rose(rx_lock_i) ##2 1 |-> rx_lock_sync[1];
  endproperty
  a_lock: assert property (p_lock) else $error("lock sync");

  property p_bypass;
    @(posedge clk_i) disable iff (rst_i)
    sh_pd_o |-> !sh_bypass_o;
  endproperty
  a_bypass: assert property (p_bypass) else $error("bypass on pd");

  property p_rsvd;
    @(posedge clk_i) disable iff (rst_i)
    receive_synth_divider_cfg[7] == 1'b0 &&
      startup_source_select[7:1] == 7'h00;
  endproperty
  a_rsvd: assert property (p_rsvd) else $error("reserved bits");

  property p_cs_slave;
    @(posedge clk_i) disable iff (rst_i)
    !master_mode_o |-> !chip_select_out_zero_o && !chip_select_out_one_o &&
      !chip_select_out_two_o;
  endproperty
  a_cs_slave: assert property (p_cs_slave) else $error("cs in slave");

  property p_tx_fb;
    @(posedge clk_i) disable iff (rst_i)
    wr_txd |=> tx_synth_o.fb_ratio == {1'b0, $past(wd[6:4])} + 4'h2;
  endproperty
  a_tx_fb: assert property (p_tx_fb) else $error("tx fb ratio");

  property p_rx_pwr;
    @(posedge clk_i) disable iff (rst_i)
    wr_rxp |=> {rx_synth_o.pll_off, rx_synth_o.div_off, rx_synth_o.drv_off}
      == $past(wd[2:0]);
  endproperty
  a_rx_pwr: assert property (p_rx_pwr) else $error("rx power bits");

  property p_rx_phase;
    @(posedge clk_i) disable iff (rst_i)
    wr_rxd |=> rx_synth_o.phase_sel == $past(wd[3:0]);
  endproperty
  a_rx_phase: assert property (p_rx_phase) else $error("rx phase");

  sequence s_tx_lock_read;
    psel_i && !penable_i && !pwrite_i && addr_ok && idx == IDX_TX_LOCK;
  endsequence
  property p_tx_rsvd;
    @(posedge clk_i) disable iff (rst_i)
    s_tx_lock_read |=>
      prdata_o == {24'h00_0000, $past(tx_lock_sync[1]), 7'h00};
  endproperty
  a_tx_rsvd: assert property (p_tx_rsvd) else $error("tx lock read");

  property p_kick_idle;
    @(posedge clk_i) disable iff (rst_i)
    (wr_kick && !master_mode_o && !burst_busy_o) |=> !burst_busy_o;
  endproperty
  a_kick_idle: assert property (p_kick_idle) else $error("slave kick");

endmodule
